// >>> rtl/srw_supervisor.sv
// The implementer's own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "srw_cfg.svh"

// Operation
// R01: any of four sources asserts core reset and module reset together
// R02: core held in reset; fetch starts at address 0000h after release
// R03: active-low reset to programmable module while any source is active
// R04: reset pin pulled up; spikes shorter than filter time ignored
// R05: external party holds reset pin low for the minimum time
// R06: pin-caused reset ends as soon as the pin is released
// R07: after supply recovers, reset stays asserted for a fixed active period
// R08: supply detector always enabled, even in idle and power-down
// R09: supply reset sets cold-start flag; only software write clears it
// R10: debug reset also acts in idle and power-down modes
// R11: watchdog does not count in idle or power-down
// R12: key 55h disables watchdog; any other value enables; reset loads 55h
// R13: 24-bit up-counter, cleared on reset, plus one per machine cycle
// R14: overflow past all-ones issues reset and restores key to 55h
// R15: reload write loads upper byte and clears lower 16 bits
// R16: firmware reloads before overflow; avoid too-short timeout values
// R17: machine cycle is 4 clocks, longer for slow memory or stalls
// R18: combined reset released synchronously to the core clock
// R19: counter advanced by a one-cycle machine-cycle enable pulse
module srw_supervisor #(
  parameter int FIL_NS = `SRW_FIL_NS,
  parameter int ACTV_NS = `SRW_ACTV_NS,
  parameter int CLK_NS = `SRW_CLK_NS,
  parameter int CNT_W = 24
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic reset_pin_n,
  input wire logic supply_low,
  input wire logic dbg_rst_req,
  input wire logic idle_mode,
  input wire logic power_down,
  input wire logic mem_xfer,
  input wire logic fetch_stall,
  output logic core_rst,
  output logic pmod_rst_n,
  output logic [15:0] boot_addr,
  output logic irq
);

  // =====================================================
  // timing counts
  // least times round up, never below one cycle
  localparam int FIL_RAW = (FIL_NS + CLK_NS - 1) / CLK_NS;
  localparam int FIL_CYC = (FIL_RAW < 1) ? 1 : FIL_RAW;
  localparam int ACTV_RAW = (ACTV_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACTV_CYC = (ACTV_RAW < 1) ? 1 : ACTV_RAW;
  localparam logic [7:0] FIL_C8 = 8'(FIL_CYC);
  localparam logic [19:0] ACTV_C20 = 20'(ACTV_CYC);

  // =====================================================
  // watchdog width
  // the reload byte always lands in the top eight bits; a
  // narrower counter only shortens the timeout, for tests
  localparam int LOW_W = CNT_W - 8;
  localparam logic [23:0] CNT_TOP = 24'((64'd1 << CNT_W) - 64'd1);

  // =====================================================
  // state
  srw_pkg::srw_state_s s_q;
  srw_pkg::srw_state_s s_d;

  srw_pkg::srw_req_s req;
  srw_pkg::srw_req_s rise;
  logic any_req;
  logic ahb_take;
  logic wr_now;
  logic [7:0] wr_addr;
  logic [2:0] mc_len;
  logic mc_tick;
  logic wdt_run;
  logic wdt_ovf;
  logic [4:0] sts_set;
  logic [4:0] sts_clr;
  logic [3:0] wait_clks;

  always_comb begin
    s_d = s_q;
    req = '0;
    rise = '0;
    any_req = 1'b0;
    ahb_take = 1'b0;
    wr_now = 1'b0;
    wr_addr = 8'h00;
    mc_len = `SRW_MC_BASE;
    mc_tick = 1'b0;
    wdt_run = 1'b0;
    wdt_ovf = 1'b0;
    sts_set = 5'h00;
    sts_clr = 5'h00;
    wait_clks = 4'h0;

    // =====================================================
    // pin synchronisers
    s_d.ext_s1 = reset_pin_n;
    s_d.ext_s2 = s_q.ext_s1;
    s_d.lvd_s1 = supply_low;
    s_d.lvd_s2 = s_q.lvd_s1;

    // =====================================================
    // external pin filter
    // the pull-up sits in the pad; here a low must persist
    // for the filter time before it counts as a request
    if (s_q.ext_s2) begin
      s_d.ext_fcnt = 8'h00;
      s_d.ext_act = 1'b0; // R06
    end else if (!s_q.ext_act) begin
      if (s_q.ext_fcnt >= FIL_C8 - 8'h01) begin
        s_d.ext_act = 1'b1; // R04
      end else begin
        s_d.ext_fcnt = s_q.ext_fcnt + 8'h01; // R04
      end
    end

    // =====================================================
    // supply detector
    // no enable term exists anywhere: it runs in every mode
    if (!s_q.lvd_s2) begin
      s_d.lvd_fcnt = 8'h00;
      s_d.lvd_act = 1'b0; // R08
    end else if (!s_q.lvd_act) begin
      if (s_q.lvd_fcnt >= FIL_C8 - 8'h01) begin
        s_d.lvd_act = 1'b1; // R08
      end else begin
        s_d.lvd_fcnt = s_q.lvd_fcnt + 8'h01;
      end
    end
    // active period is reloaded while the supply is low and
    // runs down only after it has come back
    if (s_q.lvd_act) begin
      s_d.hold_cnt = ACTV_C20; // R07
    end else if (s_q.hold_cnt != 20'h00000) begin
      s_d.hold_cnt = s_q.hold_cnt - 20'h00001; // R07
    end

    // =====================================================
    // request merge
    req.ext = s_q.ext_act;
    req.low_supply_detector = s_q.lvd_act || (s_q.hold_cnt != 20'h00000); // R07
    req.dbg = dbg_rst_req; // R10
    req.wdt = (s_q.wdt_hold != 3'h0);
    any_req = req.ext || req.low_supply_detector || req.dbg || req.wdt; // R01
    rise = req & ~s_q.req_prev;
    s_d.req_prev = req;

    // assert and release both on a clock edge, so every
    // consumer of the reset leaves it in the same cycle
    s_d.core_rst = any_req; // R18
    s_d.pmod_rst_n = !any_req; // R03
    s_d.boot_addr = `SRW_BOOT_ADDR; // R02

    // =====================================================
    // machine cycle enable
    wait_clks = 4'h4 + {2'b00, s_q.wait_sel};
    if (mem_xfer && (wait_clks > 4'h4)) begin
      mc_len = wait_clks[2:0] == 3'h0 ? 3'h7 : wait_clks[2:0]; // R17
    end
    // 4..7 clocks fit in three bits; a stall freezes the phase
    if (!fetch_stall) begin
      if (s_q.mc_cnt >= mc_len - 3'h1) begin
        s_d.mc_cnt = 3'h0;
        mc_tick = 1'b1; // R19
      end else begin
        s_d.mc_cnt = s_q.mc_cnt + 3'h1; // R17
      end
    end

    // =====================================================
    // watchdog
    wdt_run = (s_q.key != `SRW_KEY_OFF) && !idle_mode && !power_down; // R11 R12
    if (wdt_run && mc_tick) begin
      if (s_q.wdt_cnt == CNT_TOP) begin
        wdt_ovf = 1'b1; // R14
        s_d.wdt_cnt = `SRW_COUNT_RST;
        s_d.key = `SRW_KEY_OFF; // R14
      end else begin
        s_d.wdt_cnt = s_q.wdt_cnt + 24'h000001; // R13
      end
    end
    // a timeout gives a short reset of its own
    if (wdt_ovf) begin
      s_d.wdt_hold = `SRW_WDT_HOLD; // R14
    end else if (s_q.wdt_hold != 3'h0) begin
      s_d.wdt_hold = s_q.wdt_hold - 3'h1;
    end

    // =====================================================
    // bus slave
    // address phase captured, write applied in data phase;
    // read data prepared at the address edge, so no waits
    ahb_take = hsel && htrans[1] && hready;
    wr_now = s_q.a_we;
    wr_addr = s_q.a_addr;
    s_d.a_we = ahb_take && hwrite;
    s_d.a_addr = haddr[7:0];
    s_d.rdata = 32'h00000000;
    if (ahb_take && !hwrite) begin
      if (haddr[7:0] == `SRW_OFS_STATUS) begin
        s_d.rdata = {27'h0, s_q.sts};
      end else if (haddr[7:0] == `SRW_OFS_MASK) begin
        s_d.rdata = {27'h0, s_q.msk};
      end else if (haddr[7:0] == `SRW_OFS_COUNT) begin
        s_d.rdata = {7'h0, wdt_run, s_q.wdt_cnt};
      end else if (haddr[7:0] == `SRW_OFS_TIMING) begin
        s_d.rdata = {30'h0, s_q.wait_sel};
      end
    end

    if (wr_now) begin
      if (wr_addr == `SRW_OFS_KEY) begin
        s_d.key = hwdata[7:0]; // R12
      end else if (wr_addr == `SRW_OFS_RELOAD) begin
        s_d.wdt_cnt = {16'h0000, hwdata[7:0]} << LOW_W; // R15
      end else if (wr_addr == `SRW_OFS_STATUS) begin
        sts_clr = hwdata[4:0]; // R09
      end else if (wr_addr == `SRW_OFS_MASK) begin
        s_d.msk = hwdata[4:0];
      end else if (wr_addr == `SRW_OFS_TIMING) begin
        s_d.wait_sel = hwdata[1:0];
      end
    end

    // =====================================================
    // events and interrupt
    // a set arriving with a clear wins, so no event is lost
    sts_set[`SRW_BIT_EXT] = rise.ext;
    sts_set[`SRW_BIT_LVD] = rise.low_supply_detector;
    sts_set[`SRW_BIT_DBG] = rise.dbg;
    sts_set[`SRW_BIT_WDT] = wdt_ovf;
    sts_set[`SRW_BIT_COLD] = rise.low_supply_detector; // R09
    s_d.sts = (s_q.sts & ~sts_clr) | sts_set; // R09
    s_d.irq = |(s_d.sts & s_q.msk);

    // =====================================================
    // core reset returns the watchdog to its disabled state;
    // status, mask and timing survive so software can see why
    if (s_q.core_rst) begin
      s_d.key = `SRW_KEY_OFF; // R12
      s_d.wdt_cnt = `SRW_COUNT_RST; // R13
      s_d.mc_cnt = 3'h0;
    end
  end

  // =====================================================
  // registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.ext_s1 <= 1'b1;
      s_q.ext_s2 <= 1'b1;
      s_q.core_rst <= 1'b1; // R02
      s_q.pmod_rst_n <= 1'b0; // R03
      s_q.key <= `SRW_KEY_OFF; // R12
      s_q.wdt_cnt <= `SRW_COUNT_RST; // R13
      s_q.wait_sel <= `SRW_WAIT_RST;
      s_q.sts <= `SRW_STATUS_RST; // R09
      s_q.msk <= `SRW_MASK_RST;
      s_q.boot_addr <= `SRW_BOOT_ADDR;
    end else begin
      s_q <= s_d;
    end
  end

  // =====================================================
  // outputs straight from flip-flops; hreadyout and hresp are constants
  assign core_rst = s_q.core_rst;
  assign pmod_rst_n = s_q.pmod_rst_n;
  assign boot_addr = s_q.boot_addr;
  assign irq = s_q.irq;
  assign hrdata = s_q.rdata;
  // zero-wait slave: always ready, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

endmodule

`default_nettype wire

// >>> pkg/srw_cfg.svh
`ifndef SRW_CFG_SVH
`define SRW_CFG_SVH

// =====================================================
// register map (byte addresses)
`define SRW_OFS_KEY 8'h00
`define SRW_OFS_RELOAD 8'h04
`define SRW_OFS_STATUS 8'h08
`define SRW_OFS_MASK 8'h0C
`define SRW_OFS_COUNT 8'h10
`define SRW_OFS_TIMING 8'h14

// =====================================================
// reset values
`define SRW_KEY_OFF 8'h55
`define SRW_COUNT_RST 24'h000000
`define SRW_LOW_CLR 16'h0000
`define SRW_STATUS_RST 5'h10
`define SRW_MASK_RST 5'h00
`define SRW_WAIT_RST 2'h2
`define SRW_BOOT_ADDR 16'h0000

// =====================================================
// status and mask bit positions; bit 24 is the run flag in the count register
`define SRW_BIT_EXT 0
`define SRW_BIT_LVD 1
`define SRW_BIT_DBG 2
`define SRW_BIT_WDT 3
`define SRW_BIT_COLD 4
`define SRW_BIT_RUN 24

// =====================================================
// timing
`define SRW_CLK_NS 40
`define SRW_FIL_NS 100
`define SRW_ACTV_NS 10000
`define SRW_MC_BASE 3'h4
`define SRW_WDT_HOLD 3'h4

`endif

// >>> pkg/srw_pkg.sv
`include "srw_cfg.svh"

package srw_pkg;

  // one bit per reset source, also the layout of the event bits
  typedef struct packed {
    logic wdt;
    logic dbg;
    logic low_supply_detector;
    logic ext;
  } srw_req_s;

  typedef struct packed {
    logic ext_s1;
    logic ext_s2;
    logic lvd_s1;
    logic lvd_s2;
    logic [7:0] ext_fcnt;
    logic ext_act;
    logic [7:0] lvd_fcnt;
    logic lvd_act;
    logic [19:0] hold_cnt;
    logic [2:0] wdt_hold;
    srw_req_s req_prev;
    logic [23:0] wdt_cnt;
    logic [7:0] key;
    logic [2:0] mc_cnt;
    logic [1:0] wait_sel;
    logic [4:0] sts;
    logic [4:0] msk;
    logic core_rst;
    logic pmod_rst_n;
    logic [15:0] boot_addr;
    logic irq;
    logic a_we;
    logic [7:0] a_addr;
    logic [31:0] rdata;
  } srw_state_s;

endpackage

// >>> verification/srw_props.sv
`timescale 1ns/1ns
`default_nettype none
// ==========
// reset output checks
module srw_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic reset_pin_n,
  input wire logic supply_low,
  input wire logic dbg_rst_req,
  input wire logic core_rst,
  input wire logic pmod_rst_n,
  input wire logic [15:0] boot_addr
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence quiet;
    reset_pin_n && !supply_low && !dbg_rst_req;
  endsequence
  // one low cycle is shorter than the filter window
  sequence spike;
    !core_rst && $fell(reset_pin_n) ##1 quiet[*6];
  endsequence
  pair_rst_a: assert property (pmod_rst_n == !core_rst) else $error("module reset mismatch");
  boot_vec_a: assert property (boot_addr == 16'h0000) else $error("restart address wrong");
  dbg_src_a: assert property (dbg_rst_req |-> ##[1:2] core_rst) else $error("debug reset missed");
  pin_src_a: assert property (!reset_pin_n [*8] |-> core_rst) else $error("pin reset missed");
  pin_rel_a: assert property ($rose(reset_pin_n) ##0 quiet[*7] |-> !core_rst) else $error("pin stretch");
  spike_rej_a: assert property (spike |-> !core_rst) else $error("spike not filtered");
  supply_hold_a: assert property (supply_low [*8] ##1 !supply_low |-> core_rst [*8]) else $error("short");
  dbg_rel_a: assert property ($fell(dbg_rst_req) ##0 quiet[*4] |-> !core_rst) else $error("dbg stretch");
endmodule
`default_nettype wire

// >>> verification/srw_partner.sv
`timescale 1ns/1ns
`default_nettype none
// ==========
// reset switch and debug probe
module srw_partner (
  input wire logic hclk,
  output logic reset_pin_n,
  output logic dbg_rst_req
);
  initial begin
    reset_pin_n = 1'b1;
    dbg_rst_req = 1'b0;
  end
  // n below the minimum low time only when a spike is wanted
  task automatic press(input int n, input logic dbg);
    @(posedge hclk);
    if (dbg) begin
      dbg_rst_req <= 1'b1;
    end else begin
      reset_pin_n <= 1'b0;
    end
    repeat (n) @(posedge hclk);
    dbg_rst_req <= 1'b0;
    reset_pin_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// >>> verification/supervisor_reset_watchdog_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "srw_cfg.svh"
module supervisor_reset_watchdog_tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, rd_vld, hreadyout, supply_low, idle_mode, power_down, mem_xfer, fetch_stall;
  logic core_rst, pmod_rst_n, irq, reset_pin_n, dbg_rst_req, hresp;
  logic [31:0] haddr, hwdata, hrdata, seed;
  logic [1:0] htrans;
  logic [15:0] boot_addr;
  logic [7:0] r;
  logic [47:0] expq[$];
  int errors, checked, i;
  initial forever #20 hclk = ~hclk;
  srw_partner srw_partner_inst (.hclk, .reset_pin_n, .dbg_rst_req);
  // a 16-bit watchdog keeps a full timeout inside the run
  srw_supervisor #(.ACTV_NS(400), .CNT_W(16)) srw_supervisor_inst (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .reset_pin_n, .supply_low,
    .dbg_rst_req, .idle_mode, .power_down, .mem_xfer, .fetch_stall, .core_rst, .pmod_rst_n, .boot_addr, .irq);
  // ==========
  // checking and closing
  task automatic conclude();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic cmp_rd(input logic [47:0] e);
    checked++;
    if ((hrdata[23:0] >= e[47:24] && hrdata[23:0] <= e[23:0] && hresp === 1'b0) !== 1'b1) begin
      errors++;
      $display("Error hrdata exp %h..%h got %h", e[47:24], e[23:0], hrdata);
    end
  endtask
  task automatic cmp_irq(input logic e);
    checked++;
    if (irq !== e) begin
      errors++;
      $display("Error irq exp %b got %b", e, irq);
    end
  endtask
  task automatic cmp_rst(input logic e);
    checked++;
    if (core_rst !== e) begin
      errors++;
      $display("Error core_rst exp %b got %b", e, core_rst);
    end
  endtask
  always @(posedge hclk) begin
    if (rd_vld) cmp_rd(expq.pop_front());
  end
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  // ==========
  // bus and reset helpers
  task automatic rdy_edge();
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 50) begin
        errors++;
        conclude();
      end
      @(posedge hclk);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [23:0] d, lo, hi);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    rdy_edge();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {8'h00, d};
    rd_vld <= !w;
    if (!w) expq.push_back({lo, hi});
    rdy_edge();
    rd_vld <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    bus(a, 1'b1, d, 24'h0, 24'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [23:0] e);
    bus(a, 1'b0, 24'h0, e, e);
  endtask
  // waits out whatever reset is in flight, bounded
  task automatic run();
    for (i = 0; i < 600 && core_rst !== 1'b0; i++) @(posedge hclk);
    if (core_rst !== 1'b0) begin
      errors++;
      conclude();
    end
  endtask
  // ==========
  // main sequence
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, rd_vld} = '0;
    {supply_low, idle_mode, power_down, mem_xfer, fetch_stall} = '0;
    seed = 32'h0000005E;
    errors = 0;
    checked = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    run();
    rd(`SRW_OFS_STATUS, 24'h10);
    rd(`SRW_OFS_TIMING, 24'h2);
    rd(`SRW_OFS_KEY, 24'h0);
    rd(8'h40, 24'h0);
    rd(`SRW_OFS_COUNT, 24'h0);
    r = rnd();
    wr(`SRW_OFS_RELOAD, {16'h0, r});
    rd(`SRW_OFS_COUNT, {8'h00, r, 8'h00});
    wr(`SRW_OFS_KEY, 24'hAA);
    for (int j = 0; j < 3; j++) begin
      {fetch_stall, power_down, idle_mode} <= 3'h1 << j;
      r = rnd();
      wr(`SRW_OFS_RELOAD, {16'h0, r});
      repeat (40) @(posedge hclk);
      rd(`SRW_OFS_COUNT, {8'h00, r, 8'h00});
    end
    for (int j = 0; j < 2; j++) begin
      {fetch_stall, power_down, idle_mode} <= 3'h0;
      mem_xfer <= j[0];
      wr(`SRW_OFS_RELOAD, 24'hFF);
      repeat (400 + 200 * j) @(posedge hclk);
      bus(`SRW_OFS_COUNT, 1'b0, 24'h0, 24'h00FF63, 24'h00FF66);
    end
    // left alone, the counter runs from FF00h into its timeout
    mem_xfer <= 1'b0;
    wr(`SRW_OFS_RELOAD, 24'hFF);
    repeat (1000) @(posedge hclk);
    cmp_rst(1'b0);
    for (i = 0; i < 100 && core_rst !== 1'b1; i++) @(posedge hclk);
    cmp_rst(1'b1);
    if (core_rst !== 1'b1) conclude();
    run();
    rd(`SRW_OFS_COUNT, 24'h0);
    rd(`SRW_OFS_STATUS, 24'h18);
    wr(`SRW_OFS_STATUS, 24'h08);
    power_down <= 1'b1;
    wr(`SRW_OFS_MASK, 24'h04);
    srw_partner_inst.press(5, 1'b1);
    run();
    power_down <= 1'b0;
    repeat (40) @(posedge hclk);
    rd(`SRW_OFS_COUNT, 24'h0);
    rd(`SRW_OFS_STATUS, 24'h14);
    cmp_irq(1'b1);
    wr(`SRW_OFS_STATUS, 24'h04);
    repeat (2) @(posedge hclk);
    cmp_irq(1'b0);
    wr(`SRW_OFS_MASK, 24'h00);
    srw_partner_inst.press(5, 1'b1);
    run();
    cmp_irq(1'b0);
    srw_partner_inst.press(12, 1'b0);
    run();
    srw_partner_inst.press(1, 1'b0);
    repeat (10) @(posedge hclk);
    rd(`SRW_OFS_STATUS, 24'h15);
    wr(`SRW_OFS_STATUS, 24'h1F);
    rd(`SRW_OFS_STATUS, 24'h00);
    power_down <= 1'b1;
    supply_low <= 1'b1;
    repeat (20) @(posedge hclk);
    supply_low <= 1'b0;
    run();
    rd(`SRW_OFS_STATUS, 24'h12);
    conclude();
  end
endmodule
bind srw_supervisor srw_props srw_props_inst (.hclk, .hresetn, .reset_pin_n, .supply_low, .dbg_rst_req,
  .core_rst, .pmod_rst_n, .boot_addr);
`default_nettype wire
